//--- ieia_aggregator.v
// Event and interrupt aggregator with APB register access
//
// Function
// - New bit sets on source, write-1, or interrupt-set write-1.
// - Event view is new OR snapshot.
// - Status read ORs new into snapshot, clears new.
// - Enabled events OR-ed per group into status bits.
// - Enabled status bits OR-ed into one interrupt.
// - Status write-1 clears related enabled events in snapshot only.
// - Pending related enabled new event keeps status set.
// - Snapshot readable, bitwise clearable; new events untouched.
// - New register readable, bitwise clearable.
// - Event write-1 clears snapshot and new bits.
// - Source event beats a clear in the same cycle.
// - Event enables all set after reset.
// - Outbox-empty from outbox read; inbox-full from inbox write.
// - Boot-fail from four boot errors; boot-success from its event.
// - Target-fail from collision and three target timeouts.
// - Target write, read and success from their done events.
// - Controller diagnostic from timer, history and command-done events.
// - Controller timeout from three timeouts; collision from collision event.
// - Controller nack, arbitration timeout and success from their events.
// - Interrupt stays high while any enabled status bit is set.
`timescale 1ns/100ps
`include "ieia_consts.vh"

module ieia_aggregator (
    // Clock and reset
    input wire I_CLOCK,
    input wire I_RST_N,
    // APB slave
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [`IEIA_ADDR_W-1:0] I_PADDR,
    input wire [`IEIA_DATA_W-1:0] I_PWDATA,
    output wire O_PREADY,
    output reg [`IEIA_DATA_W-1:0] O_PRDATA,
    output wire O_PSLVERR,
    // Mailbox events
    input wire I_OUTBOX_READ_EVENT,
    input wire I_INBOX_WRITE_EVENT,
    // Boot loader events
    input wire I_BOOT_TIMEOUT_EVENT,
    input wire I_BOOT_PROTOCOL_ERROR_EVENT,
    input wire I_BOOT_SIZE_ERROR_EVENT,
    input wire I_BOOT_NO_DEVICE_EVENT,
    input wire I_BOOT_SUCCESS_EVENT,
    // Target engine events
    input wire I_TARGET_COLLISION_EVENT,
    input wire I_TARGET_TRANSACTION_TIMEOUT_EVENT,
    input wire I_TARGET_BYTE_TIMEOUT_EVENT,
    input wire I_TARGET_CLOCK_LOW_TIMEOUT_EVENT,
    input wire I_TARGET_REG_WRITE_DONE_EVENT,
    input wire I_TARGET_REG_READ_DONE_EVENT,
    input wire I_TARGET_TRANSACTION_DONE_EVENT,
    // Diagnostic events
    input wire I_DIAG_TIMER_EXPIRED_EVENT,
    input wire I_DIAG_HISTORY_FILLING_EVENT,
    input wire I_DIAG_COMMAND_DONE_EVENT,
    // Controller engine events
    input wire I_CONTROLLER_COLLISION_EVENT,
    input wire I_CONTROLLER_TRANSACTION_TIMEOUT_EVENT,
    input wire I_CONTROLLER_BYTE_TIMEOUT_EVENT,
    input wire I_CONTROLLER_CLOCK_LOW_TIMEOUT_EVENT,
    input wire I_CONTROLLER_NACK_RECEIVED_EVENT,
    input wire I_CONTROLLER_ARBITRATION_TIMEOUT_EVENT,
    input wire I_CONTROLLER_TRANSACTION_DONE_EVENT,
    // Interrupt toward the chip interrupt controller
    output reg O_IRQ,
    output reg [`IEIA_NUM_STATUS-1:0] O_INT_STATUS
);

    ////////////////////////////////////////////////////////////////////////
    // Address match, used for every register
    function hit;
        input [`IEIA_ADDR_W-1:0] addr;
        input [`IEIA_ADDR_W-1:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    // State
    reg [`IEIA_NUM_EVENTS-1:0] new_event;
    reg [`IEIA_NUM_EVENTS-1:0] event_snapshot_register;
    reg [`IEIA_NUM_EVENTS-1:0] event_enable;
    reg [`IEIA_NUM_STATUS-1:0] int_enable;
    reg slv_err;

    // Combinational
    wire [`IEIA_NUM_EVENTS-1:0] src_event;
    wire [`IEIA_NUM_EVENTS-1:0] event_view;
    wire [`IEIA_NUM_EVENTS-1:0] enabled_event;
    wire [`IEIA_NUM_STATUS-1:0] int_status;
    wire [`IEIA_NUM_STATUS-1:0] status_sel;
    wire [`IEIA_NUM_EVENTS-1:0] sel_event;
    wire [`IEIA_NUM_EVENTS-1:0] wr_event;
    wire setup;
    wire wr;
    wire rd_setup;
    wire snapshot;
    wire wr_int_stat;
    wire wr_int_en;
    wire wr_int_set;
    wire wr_new;
    wire wr_new_set;
    wire wr_snap;
    wire wr_event_view;
    wire wr_event_en;
    wire mapped;
    reg [`IEIA_NUM_EVENTS-1:0] clr_new;
    reg [`IEIA_NUM_EVENTS-1:0] set_new;
    reg [`IEIA_NUM_EVENTS-1:0] clr_snap;
    reg [`IEIA_NUM_EVENTS-1:0] next_new_event;
    reg [`IEIA_NUM_EVENTS-1:0] next_snap;
    reg [`IEIA_DATA_W-1:0] next_prdata;

    ////////////////////////////////////////////////////////////////////////
    // Source events onto fixed bits; same clock, no synchroniser
    assign src_event[`IEIA_EV_OUTBOX_READ] = I_OUTBOX_READ_EVENT;
    assign src_event[`IEIA_EV_INBOX_WRITE] = I_INBOX_WRITE_EVENT;
    assign src_event[`IEIA_EV_BOOT_TIMEOUT] = I_BOOT_TIMEOUT_EVENT;
    assign src_event[`IEIA_EV_BOOT_PROTOCOL_ERROR] = I_BOOT_PROTOCOL_ERROR_EVENT;
    assign src_event[`IEIA_EV_BOOT_SIZE_ERROR] = I_BOOT_SIZE_ERROR_EVENT;
    assign src_event[`IEIA_EV_BOOT_NO_DEVICE] = I_BOOT_NO_DEVICE_EVENT;
    assign src_event[`IEIA_EV_BOOT_SUCCESS] = I_BOOT_SUCCESS_EVENT;
    assign src_event[`IEIA_EV_TGT_COLLISION] = I_TARGET_COLLISION_EVENT;
    assign src_event[`IEIA_EV_TGT_TRANS_TIMEOUT] = I_TARGET_TRANSACTION_TIMEOUT_EVENT;
    assign src_event[`IEIA_EV_TGT_BYTE_TIMEOUT] = I_TARGET_BYTE_TIMEOUT_EVENT;
    assign src_event[`IEIA_EV_TGT_CLK_LOW_TIMEOUT] = I_TARGET_CLOCK_LOW_TIMEOUT_EVENT;
    assign src_event[`IEIA_EV_TGT_REG_WRITE_DONE] = I_TARGET_REG_WRITE_DONE_EVENT;
    assign src_event[`IEIA_EV_TGT_REG_READ_DONE] = I_TARGET_REG_READ_DONE_EVENT;
    assign src_event[`IEIA_EV_TGT_TRANS_DONE] = I_TARGET_TRANSACTION_DONE_EVENT;
    assign src_event[`IEIA_EV_DIAG_TIMER_EXPIRED] = I_DIAG_TIMER_EXPIRED_EVENT;
    assign src_event[`IEIA_EV_DIAG_HISTORY_FILLING] = I_DIAG_HISTORY_FILLING_EVENT;
    assign src_event[`IEIA_EV_DIAG_COMMAND_DONE] = I_DIAG_COMMAND_DONE_EVENT;
    assign src_event[`IEIA_EV_CTRL_COLLISION] = I_CONTROLLER_COLLISION_EVENT;
    assign src_event[`IEIA_EV_CTRL_TRANS_TIMEOUT] = I_CONTROLLER_TRANSACTION_TIMEOUT_EVENT;
    assign src_event[`IEIA_EV_CTRL_BYTE_TIMEOUT] = I_CONTROLLER_BYTE_TIMEOUT_EVENT;
    assign src_event[`IEIA_EV_CTRL_CLK_LOW_TIMEOUT] = I_CONTROLLER_CLOCK_LOW_TIMEOUT_EVENT;
    assign src_event[`IEIA_EV_CTRL_NACK_RECEIVED] = I_CONTROLLER_NACK_RECEIVED_EVENT;
    assign src_event[`IEIA_EV_CTRL_ARB_TIMEOUT] = I_CONTROLLER_ARBITRATION_TIMEOUT_EVENT;
    assign src_event[`IEIA_EV_CTRL_TRANS_DONE] = I_CONTROLLER_TRANSACTION_DONE_EVENT;

    ////////////////////////////////////////////////////////////////////////
    // Event view and status; view needs no storage
    assign event_view = new_event | event_snapshot_register;
    assign enabled_event = event_view & event_enable;

    // Grouping of events into status bits and back
    ieia_group_map u_map (
        .i_event(enabled_event),
        .o_status(int_status),
        .i_status_sel(status_sel),
        .o_event_sel(sel_event)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB phases; zero wait states so pready is always high
    assign O_PREADY = 1'b1;
    assign setup = I_PSEL & ~I_PENABLE;
    assign wr = I_PSEL & I_PENABLE & I_PWRITE;
    assign rd_setup = setup & ~I_PWRITE;
    assign O_PSLVERR = I_PSEL & I_PENABLE & slv_err;

    // Snapshot taken with the status read data, so the read and the
    // snapshot see the same set of events
    assign snapshot = rd_setup & hit(I_PADDR, `IEIA_OFF_INT_STAT);

    // Write decode at the access edge
    assign wr_int_stat = wr & hit(I_PADDR, `IEIA_OFF_INT_STAT);
    assign wr_int_en = wr & hit(I_PADDR, `IEIA_OFF_INT_EN);
    assign wr_int_set = wr & hit(I_PADDR, `IEIA_OFF_INT_SET);
    assign wr_new = wr & hit(I_PADDR, `IEIA_OFF_NEW_EVENT);
    assign wr_new_set = wr & hit(I_PADDR, `IEIA_OFF_NEW_SET);
    assign wr_snap = wr & hit(I_PADDR, `IEIA_OFF_SNAP_EVENT);
    assign wr_event_view = wr & hit(I_PADDR, `IEIA_OFF_EVENT);
    assign wr_event_en = wr & hit(I_PADDR, `IEIA_OFF_EVENT_EN);

    // Status-bit data for both status clear and interrupt set
    assign status_sel = I_PWDATA[`IEIA_NUM_STATUS-1:0];
    assign wr_event = I_PWDATA[`IEIA_NUM_EVENTS-1:0];

    // Any defined offset
    assign mapped = hit(I_PADDR, `IEIA_OFF_INT_STAT) | hit(I_PADDR, `IEIA_OFF_INT_EN)
        | hit(I_PADDR, `IEIA_OFF_INT_SET) | hit(I_PADDR, `IEIA_OFF_NEW_EVENT)
        | hit(I_PADDR, `IEIA_OFF_NEW_SET) | hit(I_PADDR, `IEIA_OFF_SNAP_EVENT)
        | hit(I_PADDR, `IEIA_OFF_EVENT) | hit(I_PADDR, `IEIA_OFF_EVENT_EN);

    ////////////////////////////////////////////////////////////////////////
    // Set and clear terms of the new-event register
    always @* begin
        clr_new = `IEIA_EVENT_ZERO;
        set_new = src_event;
        if (snapshot) begin
            clr_new = `IEIA_EVENT_ONES;
        end
        if (wr_new) begin
            clr_new = clr_new | wr_event;
        end
        if (wr_event_view) begin
            clr_new = clr_new | wr_event;
        end
        if (wr_new_set) begin
            set_new = set_new | wr_event;
        end
        if (wr_int_set) begin
            set_new = set_new | sel_event;
        end
    end

    // Set beats clear
    always @* begin
        next_new_event = (new_event & ~clr_new) | set_new;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clear terms of the snapshot register; new events stay intact here,
    // which keeps the status set if a fresh event arrived after the read
    always @* begin
        clr_snap = `IEIA_EVENT_ZERO;
        if (wr_int_stat) begin
            clr_snap = sel_event & event_enable;
        end
        if (wr_snap) begin
            clr_snap = clr_snap | wr_event;
        end
        if (wr_event_view) begin
            clr_snap = clr_snap | wr_event;
        end
    end

    // Snapshot ORs pending new events in
    always @* begin
        next_snap = event_snapshot_register & ~clr_snap;
        if (snapshot) begin
            next_snap = next_snap | new_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event registers
    always @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            new_event <= `IEIA_EVENT_ZERO;
            event_snapshot_register <= `IEIA_EVENT_ZERO;
        end else begin
            new_event <= next_new_event;
            event_snapshot_register <= next_snap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable registers; all events enabled by default
    always @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            event_enable <= `IEIA_EVENT_EN_RESET;
            int_enable <= `IEIA_INT_EN_RESET;
        end else begin
            if (wr_event_en) begin
                event_enable <= wr_event;
            end
            if (wr_int_en) begin
                int_enable <= status_sel;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, latched in the setup cycle
    always @* begin
        next_prdata = `IEIA_DATA_ZERO;
        if (hit(I_PADDR, `IEIA_OFF_INT_STAT)) begin
            next_prdata[`IEIA_NUM_STATUS-1:0] = int_status;
        end
        if (hit(I_PADDR, `IEIA_OFF_INT_EN)) begin
            next_prdata[`IEIA_NUM_STATUS-1:0] = int_enable;
        end
        if (hit(I_PADDR, `IEIA_OFF_NEW_EVENT)) begin
            next_prdata[`IEIA_NUM_EVENTS-1:0] = new_event;
        end
        if (hit(I_PADDR, `IEIA_OFF_NEW_SET)) begin
            next_prdata[`IEIA_NUM_EVENTS-1:0] = new_event;
        end
        if (hit(I_PADDR, `IEIA_OFF_SNAP_EVENT)) begin
            next_prdata[`IEIA_NUM_EVENTS-1:0] = event_snapshot_register;
        end
        if (hit(I_PADDR, `IEIA_OFF_EVENT)) begin
            next_prdata[`IEIA_NUM_EVENTS-1:0] = event_view;
        end
        if (hit(I_PADDR, `IEIA_OFF_EVENT_EN)) begin
            next_prdata[`IEIA_NUM_EVENTS-1:0] = event_enable;
        end
    end

    // Bus response; error for undefined offsets
    always @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            O_PRDATA <= `IEIA_DATA_ZERO;
            slv_err <= 1'b0;
        end else if (setup) begin
            O_PRDATA <= I_PWRITE ? `IEIA_DATA_ZERO : next_prdata;
            slv_err <= ~mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt line and status mirror; registered for a clean output,
    // at the price of one cycle of latency behind the status
    always @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            O_IRQ <= 1'b0;
            O_INT_STATUS <= `IEIA_STATUS_ZERO;
        end else begin
            O_IRQ <= |(int_status & int_enable);
            O_INT_STATUS <= int_status;
        end
    end

endmodule

//--- ieia_consts.vh
// Constants for the event and interrupt aggregator
`ifndef IEIA_CONSTS_VH
`define IEIA_CONSTS_VH

// Widths
`define IEIA_NUM_EVENTS 24
`define IEIA_NUM_STATUS 14
`define IEIA_ADDR_W 8
`define IEIA_DATA_W 32

// Register byte offsets
`define IEIA_OFF_INT_STAT 8'h00
`define IEIA_OFF_INT_EN 8'h04
`define IEIA_OFF_INT_SET 8'h08
`define IEIA_OFF_NEW_EVENT 8'h0C
`define IEIA_OFF_NEW_SET 8'h10
`define IEIA_OFF_SNAP_EVENT 8'h14
`define IEIA_OFF_EVENT 8'h18
`define IEIA_OFF_EVENT_EN 8'h1C

// Reset values
`define IEIA_EVENT_EN_RESET 24'hFFFFFF
`define IEIA_INT_EN_RESET 14'h0000
`define IEIA_EVENT_ZERO 24'h000000
`define IEIA_EVENT_ONES 24'hFFFFFF
`define IEIA_STATUS_ZERO 14'h0000
`define IEIA_DATA_ZERO 32'h00000000

// Event bit positions
`define IEIA_EV_OUTBOX_READ 0
`define IEIA_EV_INBOX_WRITE 1
`define IEIA_EV_BOOT_TIMEOUT 2
`define IEIA_EV_BOOT_PROTOCOL_ERROR 3
`define IEIA_EV_BOOT_SIZE_ERROR 4
`define IEIA_EV_BOOT_NO_DEVICE 5
`define IEIA_EV_BOOT_SUCCESS 6
`define IEIA_EV_TGT_COLLISION 7
`define IEIA_EV_TGT_TRANS_TIMEOUT 8
`define IEIA_EV_TGT_BYTE_TIMEOUT 9
`define IEIA_EV_TGT_CLK_LOW_TIMEOUT 10
`define IEIA_EV_TGT_REG_WRITE_DONE 11
`define IEIA_EV_TGT_REG_READ_DONE 12
`define IEIA_EV_TGT_TRANS_DONE 13
`define IEIA_EV_DIAG_TIMER_EXPIRED 14
`define IEIA_EV_DIAG_HISTORY_FILLING 15
`define IEIA_EV_DIAG_COMMAND_DONE 16
`define IEIA_EV_CTRL_COLLISION 17
`define IEIA_EV_CTRL_TRANS_TIMEOUT 18
`define IEIA_EV_CTRL_BYTE_TIMEOUT 19
`define IEIA_EV_CTRL_CLK_LOW_TIMEOUT 20
`define IEIA_EV_CTRL_NACK_RECEIVED 21
`define IEIA_EV_CTRL_ARB_TIMEOUT 22
`define IEIA_EV_CTRL_TRANS_DONE 23

// Events belonging to each status bit, index = status bit position
`define IEIA_GRP_OUTBOX_EMPTY 24'h000001
`define IEIA_GRP_INBOX_FULL 24'h000002
`define IEIA_GRP_BOOT_LOAD_FAIL 24'h00003C
`define IEIA_GRP_BOOT_LOAD_SUCCESS 24'h000040
`define IEIA_GRP_TGT_ACCESS_FAIL 24'h000780
`define IEIA_GRP_TGT_WRITE 24'h000800
`define IEIA_GRP_TGT_READ 24'h001000
`define IEIA_GRP_TGT_SUCCESS 24'h002000
`define IEIA_GRP_CTRL_DIAGNOSTIC 24'h01C000
`define IEIA_GRP_CTRL_COLLISION 24'h020000
`define IEIA_GRP_CTRL_TIMEOUT 24'h1C0000
`define IEIA_GRP_CTRL_NACK 24'h200000
`define IEIA_GRP_CTRL_ARB_TIMEOUT 24'h400000
`define IEIA_GRP_CTRL_SUCCESS 24'h800000

`endif

//--- ieia_group_map.v
// Status bit grouping of events, both directions
`timescale 1ns/100ps
`include "ieia_consts.vh"

module ieia_group_map (
    // Enabled events in, status out
    input wire [`IEIA_NUM_EVENTS-1:0] i_event,
    output wire [`IEIA_NUM_STATUS-1:0] o_status,
    // Status bit selection in, related events out
    input wire [`IEIA_NUM_STATUS-1:0] i_status_sel,
    output reg [`IEIA_NUM_EVENTS-1:0] o_event_sel
);

    // Event mask of one status bit
    function [`IEIA_NUM_EVENTS-1:0] grp_mask;
        input integer s;
        begin
            case (s)
                0: grp_mask = `IEIA_GRP_OUTBOX_EMPTY;
                1: grp_mask = `IEIA_GRP_INBOX_FULL;
                2: grp_mask = `IEIA_GRP_BOOT_LOAD_FAIL;
                3: grp_mask = `IEIA_GRP_BOOT_LOAD_SUCCESS;
                4: grp_mask = `IEIA_GRP_TGT_ACCESS_FAIL;
                5: grp_mask = `IEIA_GRP_TGT_WRITE;
                6: grp_mask = `IEIA_GRP_TGT_READ;
                7: grp_mask = `IEIA_GRP_TGT_SUCCESS;
                8: grp_mask = `IEIA_GRP_CTRL_DIAGNOSTIC;
                9: grp_mask = `IEIA_GRP_CTRL_COLLISION;
                10: grp_mask = `IEIA_GRP_CTRL_TIMEOUT;
                11: grp_mask = `IEIA_GRP_CTRL_NACK;
                12: grp_mask = `IEIA_GRP_CTRL_ARB_TIMEOUT;
                13: grp_mask = `IEIA_GRP_CTRL_SUCCESS;
                default: grp_mask = `IEIA_EVENT_ZERO;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Each status bit is the OR of its enabled events
    genvar g;
    generate
        for (g = 0; g < `IEIA_NUM_STATUS; g = g + 1) begin : g_status
            assign o_status[g] = |(i_event & grp_mask(g));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Expand selected status bits back to their events
    integer k;
    always @* begin
        o_event_sel = `IEIA_EVENT_ZERO;
        for (k = 0; k < `IEIA_NUM_STATUS; k = k + 1) begin
            if (i_status_sel[k]) begin
                o_event_sel = o_event_sel | grp_mask(k);
            end
        end
    end

endmodule

//--- ieia_aggregator_assertions.sv
// Concurrent checks on the aggregator ports
`timescale 1ns/100ps
`include "ieia_consts.vh"

module ieia_aggregator_chk (
    // Clock and reset
    input wire I_CLOCK,
    input wire I_RST_N,
    // APB
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [`IEIA_ADDR_W-1:0] I_PADDR,
    input wire [`IEIA_DATA_W-1:0] I_PWDATA,
    input wire O_PREADY,
    input wire [`IEIA_DATA_W-1:0] O_PRDATA,
    input wire O_PSLVERR,
    // Interrupt side
    input wire O_IRQ,
    input wire [`IEIA_NUM_STATUS-1:0] O_INT_STATUS
);
    ////////////////////////////////////////////////////////////
    // Status read setup, write access
    wire rd_stat = I_PSEL && !I_PENABLE && !I_PWRITE && (I_PADDR == `IEIA_OFF_INT_STAT);
    wire wr_stat = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && (I_PADDR == `IEIA_OFF_INT_STAT);
    reg [13:0] wd1;

    // Write data one cycle back
    always @(posedge I_CLOCK) begin
        wd1 <= I_PWDATA[13:0];
    end

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);

    ////////////////////////////////////////////////////////////
    AST_RD_DATA: assert property (rd_stat |=> O_PRDATA == {18'h00000, O_INT_STATUS})
        else $error("status read data differs from status");
    // Snapshot only moves bits
    AST_RD_KEEP: assert property (rd_stat |-> ##2 ((O_INT_STATUS & $past(O_INT_STATUS)) == $past(O_INT_STATUS)))
        else $error("status bit lost by a status read");
    AST_W1C_OTHERS: assert property (wr_stat |-> ##2 ((O_INT_STATUS & ~$past(wd1) & $past(O_INT_STATUS))
        == ($past(O_INT_STATUS) & ~$past(wd1))))
        else $error("status clear touched an unselected bit");
    AST_IRQ_NEEDS_STAT: assert property (O_IRQ |-> O_INT_STATUS != 14'h0000)
        else $error("interrupt high with no status bit");
    AST_SLVERR_PHASE: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
        else $error("slave error outside access phase");
    AST_SLVERR_DATA: assert property (O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h00000000)
        else $error("refused read returned data");
    AST_READY: assert property (I_PSEL |-> O_PREADY)
        else $error("ready low during a transfer");
    AST_RESET_CLEAN: assert property ($rose(I_RST_N) |-> (!O_IRQ && O_INT_STATUS == 14'h0000) [*2])
        else $error("interrupt side not clear after reset");
endmodule

//--- ieia_event_src.sv
// Event source model for the engines
`timescale 1ns/100ps

module ieia_event_src (
    // Clock
    input wire i_clock,
    // Request from the bench
    input wire i_fire,
    input wire [23:0] i_req,
    // Event lines toward the aggregator
    output reg [23:0] o_event
);
    ////////////////////////////////////////////////////////////
    // One-cycle strobes
    initial o_event = 24'h000000;
    always @(posedge i_clock) begin
        o_event <= i_fire ? i_req : 24'h000000; // Source assertion
    end
endmodule

//--- ieia_tb.sv
// Testbench of the aggregator
`timescale 1ns/100ps
`include "ieia_consts.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module tb;
    localparam [7:0] A_ST = `IEIA_OFF_INT_STAT, A_EN = `IEIA_OFF_INT_EN, A_SET = `IEIA_OFF_INT_SET;
    localparam [7:0] A_NEW = `IEIA_OFF_NEW_EVENT, A_NS = `IEIA_OFF_NEW_SET, A_SN = `IEIA_OFF_SNAP_EVENT;
    localparam [7:0] A_EV = `IEIA_OFF_EVENT, A_EE = `IEIA_OFF_EVENT_EN;
    localparam [14*24-1:0] GM = {`IEIA_GRP_CTRL_SUCCESS, `IEIA_GRP_CTRL_ARB_TIMEOUT, `IEIA_GRP_CTRL_NACK,
        `IEIA_GRP_CTRL_TIMEOUT, `IEIA_GRP_CTRL_COLLISION, `IEIA_GRP_CTRL_DIAGNOSTIC, `IEIA_GRP_TGT_SUCCESS,
        `IEIA_GRP_TGT_READ, `IEIA_GRP_TGT_WRITE, `IEIA_GRP_TGT_ACCESS_FAIL, `IEIA_GRP_BOOT_LOAD_SUCCESS,
        `IEIA_GRP_BOOT_LOAD_FAIL, `IEIA_GRP_INBOX_FULL, `IEIA_GRP_OUTBOX_EMPTY};
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0, slverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, e;
    logic [23:0] req = 24'h000000, r, c, n;
    wire pready, pslverr, irq;
    wire [31:0] prdata;
    wire [13:0] int_status;
    wire [23:0] ev;
    logic [31:0] exp_q[$];
    integer errors = 0, cmp_count = 0, cyc = 0, i, s, seed;

    ////////////////////////////////////////////////////////////
    // Clock, timeout
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            errors++;
            test_done;
        end
    end

    ieia_event_src ieia_event_src_inst (.i_clock(clk), .i_fire(fire), .i_req(req), .o_event(ev));
    ieia_aggregator ieia_aggregator_inst (.I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
        .O_PSLVERR(pslverr), .I_OUTBOX_READ_EVENT(ev[0]), .I_INBOX_WRITE_EVENT(ev[1]),
        .I_BOOT_TIMEOUT_EVENT(ev[2]), .I_BOOT_PROTOCOL_ERROR_EVENT(ev[3]), .I_BOOT_SIZE_ERROR_EVENT(ev[4]),
        .I_BOOT_NO_DEVICE_EVENT(ev[5]), .I_BOOT_SUCCESS_EVENT(ev[6]), .I_TARGET_COLLISION_EVENT(ev[7]),
        .I_TARGET_TRANSACTION_TIMEOUT_EVENT(ev[8]), .I_TARGET_BYTE_TIMEOUT_EVENT(ev[9]),
        .I_TARGET_CLOCK_LOW_TIMEOUT_EVENT(ev[10]), .I_TARGET_REG_WRITE_DONE_EVENT(ev[11]),
        .I_TARGET_REG_READ_DONE_EVENT(ev[12]), .I_TARGET_TRANSACTION_DONE_EVENT(ev[13]),
        .I_DIAG_TIMER_EXPIRED_EVENT(ev[14]), .I_DIAG_HISTORY_FILLING_EVENT(ev[15]),
        .I_DIAG_COMMAND_DONE_EVENT(ev[16]), .I_CONTROLLER_COLLISION_EVENT(ev[17]),
        .I_CONTROLLER_TRANSACTION_TIMEOUT_EVENT(ev[18]), .I_CONTROLLER_BYTE_TIMEOUT_EVENT(ev[19]),
        .I_CONTROLLER_CLOCK_LOW_TIMEOUT_EVENT(ev[20]), .I_CONTROLLER_NACK_RECEIVED_EVENT(ev[21]),
        .I_CONTROLLER_ARBITRATION_TIMEOUT_EVENT(ev[22]), .I_CONTROLLER_TRANSACTION_DONE_EVENT(ev[23]),
        .O_IRQ(irq), .O_INT_STATUS(int_status));

    ////////////////////////////////////////////////////////////
    // Expected status
    function [13:0] gof(input [23:0] x);
        integer k;
        begin
            for (k = 0; k < 14; k = k + 1) begin
                gof[k] = |(x & GM[k*24 +: 24]);
            end
        end
    endfunction

    // APB master, held until pready
    task apb(input w, input [7:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            t = 0;
            @(posedge clk);
            while (pready !== 1'b1 && t < 50) begin
                t = t + 1;
                @(posedge clk);
            end
            slverr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rd(input [7:0] a, input [31:0] x);
        begin
            exp_q.push_back(x);
            apb(1'b0, a, 32'h00000000);
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Strobe events, let status settle
    task pulse(input [23:0] x);
        begin
            @(posedge clk);
            req <= x;
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    // Oldest note against each completed read
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            `CHK("prdata", e, prdata)
        end
    end

    task test_done;
        begin
            $display("errors %0d compares %0d", errors, cmp_count);
            if (errors == 0 && cmp_count > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = $urandom(32'hB2B82252);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i = i + 1) rd(8'(i * 4), (i == 7) ? 32'h00FFFFFF : 32'h00000000); // Reset
        rd(8'h20, 32'h00000000);
        `CHK("pslverr", 1'b1, slverr)
        // Each event alone
        for (i = 0; i < 24; i = i + 1) begin
            pulse(24'h000001 << i);
            `CHK("int_status", gof(24'h000001 << i), int_status) // Map
            rd(A_ST, {18'h00000, gof(24'h000001 << i)});
            rd(A_SN, 32'h00000001 << i);
            rd(A_NEW, 32'h00000000);
            wr(A_EV, 32'h00000001 << i);
            rd(A_EV, 32'h00000000);
        end
        // Event after the read survives clear
        pulse(24'h000001);
        rd(A_ST, 32'h00000001);
        pulse(24'h000001);
        wr(A_ST, 32'h00000001);
        rd(A_SN, 32'h00000000);
        rd(A_NEW, 32'h00000001);
        rd(A_ST, 32'h00000001);
        wr(A_ST, 32'h00000001);
        rd(A_ST, 32'h00000000);
        pulse(24'h000002);
        wr(A_ST, 32'h00000002);
        rd(A_NEW, 32'h00000002); // Clear without read
        // Interrupt line enable and hold
        wr(A_EN, 32'h00000009);
        pulse(24'h000041);
        `CHK("irq", 1'b1, irq)
        rd(A_ST, 32'h0000000B);
        wr(A_ST, 32'h00000003);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        wr(A_ST, 32'h00000008);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        pulse(24'h000004);
        `CHK("irq", 1'b0, irq)
        wr(A_EV, 32'h00FFFFFF);
        // Event enable masks status and clear
        wr(A_EE, 32'h00FFFFFB);
        pulse(24'h000004);
        `CHK("int_status", 14'h0000, int_status)
        pulse(24'h000008);
        rd(A_ST, 32'h00000004);
        wr(A_ST, 32'h00000004);
        rd(A_SN, 32'h00000004);
        wr(A_EV, 32'h00FFFFFF);
        wr(A_EE, 32'h00FFFFFF);
        // Random traffic
        for (i = 0; i < 6; i = i + 1) begin
            r = 24'($urandom);
            c = 24'($urandom);
            s = $urandom_range(13, 0);
            wr(A_NS, {8'hA5, r});
            rd(A_NEW, {8'h00, r});
            wr(A_NEW, {8'h5A, c});
            n = (r & ~c) | GM[s*24 +: 24];
            wr(A_SET, 32'h00000001 << s);
            rd(A_SET, 32'h00000000);
            rd(A_NEW, {8'h00, n});
            rd(A_ST, {18'h00000, gof(n)});
            c = 24'($urandom);
            wr(A_SN, {8'h00, c});
            rd(A_SN, {8'h00, n & ~c});
            rd(A_EV, {8'h00, n & ~c});
            wr(A_EV, 32'h00FFFFFF);
        end
        // Strobe in the clear's cycle
        fork
            wr(A_EV, 32'h00800000);
            begin
                @(posedge clk);
                req <= 24'h800000;
                fire <= 1'b1;
                @(posedge clk);
                fire <= 1'b0;
            end
        join
        rd(A_EV, 32'h00800000);
        wr(8'h24, 32'hFFFFFFFF);
        `CHK("pslverr", 1'b1, slverr)
        test_done;
    end
endmodule

bind ieia_aggregator ieia_aggregator_chk ieia_aggregator_chk_inst (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ), .O_INT_STATUS(O_INT_STATUS));
